/* core/irq_prio_consts.vh */
// constants for the two-level interrupt priority controller
// assumes an 8-bit special-function register port from the core
// Contract
// - priority register bits 6..0 pick high (1) or low (0) per primary source
// - bit 7 of priority and secondary registers is unimplemented, writes ignored
// - secondary bits 6,5,4 hold interval counter, supply monitor, serial priorities
// - secondary bits 2,1,0 enable interval counter, supply monitor, serial sources
// - enabled high-level request preempts a low-level service routine
// - simultaneous requests of different level: high level served first
// - no request preempts a routine running at its own level
// - equal level requests resolved by fixed polling rank
// - on accept core pushes pc and loads fixed vector; ext 0 is 0003h
// - global enable gates every source
// - enable register bits 6..0 enable the primary sources
// - priority register at b8h, bit addressable, resets to 00h
`ifndef IRQ_PRIO_CONSTS_VH
`define IRQ_PRIO_CONSTS_VH
`define ADDR_ENABLE      8'ha8
`define ADDR_SECONDARY   8'ha9
`define ADDR_PRIORITY    8'hb8
`define RST_ENABLE       8'h00
`define RST_SECONDARY    8'ha0
`define RST_PRIORITY     8'h00
`define MASK_PRIORITY    8'h7f
`define MASK_SECONDARY   8'h77
`define BIT_GLOBAL_EN    7
`define BIT_SEC_ENABLE0  0
`define BIT_SEC_PRIO0    4
`define SEC_FIELD_W      3
`define POS_EXT0         0
`define POS_TIMER0       1
`define POS_EXT1         2
`define POS_TIMER1       3
`define POS_UART         4
`define POS_TIMER2       5
`define POS_CONVERTER    6
`define POS_SEC_SERIAL   0
`define POS_SEC_SUPPLY   1
`define POS_SEC_INTERVAL 2
`define RANK_SUPPLY      4'h0
`define RANK_WATCHDOG    4'h1
`define RANK_EXT0        4'h2
`define RANK_CONVERTER   4'h3
`define RANK_TIMER0      4'h4
`define RANK_EXT1        4'h5
`define RANK_TIMER1      4'h6
`define RANK_SERIAL      4'h7
`define RANK_UART        4'h8
`define RANK_TIMER2      4'h9
`define RANK_INTERVAL    4'ha
`define RANK_NONE        4'hf
`define SLOT_SUPPLY      4'h8
`define SLOT_WATCHDOG    4'hb
`define SLOT_EXT0        4'h0
`define SLOT_CONVERTER   4'h6
`define SLOT_TIMER0      4'h1
`define SLOT_EXT1        4'h2
`define SLOT_TIMER1      4'h3
`define SLOT_SERIAL      4'h7
`define SLOT_UART        4'h4
`define SLOT_TIMER2      4'h5
`define SLOT_INTERVAL    4'h9
`define RST_VECTOR       16'h0000
`define RST_RANK         4'h0
`define NUM_SRC          11
`define VEC_BASE         16'h0003
`define VEC_STEP         16'h0008
`endif

/* core/irq_prio.v */
// two-level interrupt priority controller with polling arbitration
// assumes core presents sfr writes/reads and a return-from-interrupt pulse
// assumes request inputs are level signals already synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "irq_prio_consts.vh"
module irq_prio (
  input  wire        sys_clk,
  input  wire        nrst,
  input  wire        sfr_wr,
  input  wire        sfr_bit_wr,
  input  wire [7:0]  sfr_addr,
  input  wire [2:0]  sfr_bit_sel,
  input  wire [7:0]  sfr_wdata,
  output reg  [7:0]  sfr_rdata,
  input  wire        supply_monitor_request,
  input  wire        watchdog_request,
  input  wire        external_zero_request,
  input  wire        converter_ready_request,
  input  wire        timer_zero_overflow,
  input  wire        external_one_request,
  input  wire        timer_one_overflow,
  input  wire        serial_sync_request,
  input  wire        uart_rx_tx_request,
  input  wire        timer_two_request,
  input  wire        interval_counter_request,
  input  wire        irq_ack,
  input  wire        irq_return,
  output wire        irq_req,
  output reg  [15:0] irq_vector,
  output reg  [3:0]  irq_rank,
  output reg         irq_push_pc,
  output reg         in_service_high,
  output reg         in_service_low
);
  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  reg  [7:0]  primary_enable_reg_r;
  reg  [7:0]  primary_priority_select_r;
  reg  [7:0]  secondary_enable_priority_r;
  reg  [7:0]  primary_enable_reg_nxt;
  reg  [7:0]  primary_priority_select_nxt;
  reg  [7:0]  secondary_enable_priority_nxt;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  wire        any_write;
  wire        hit_enable;
  wire        hit_priority;
  wire        hit_secondary;

  // byte and bit writes both reach the two bit-addressable registers
  assign any_write     = sfr_wr || sfr_bit_wr;
  assign hit_enable    = any_write && (sfr_addr == `ADDR_ENABLE);
  assign hit_priority  = any_write && (sfr_addr == `ADDR_PRIORITY);
  // the secondary register is not bit addressable, so bit writes miss it
  assign hit_secondary = sfr_wr && (sfr_addr == `ADDR_SECONDARY);

  // one bit of a register replaced by din, the others kept
  function [7:0] merge_bit;
    input [7:0] old;
    input [2:0] sel;
    input       din;
    reg   [7:0] one;
    begin
      one       = 8'h01 << sel;
      merge_bit = din ? (old | one) : (old & ~one);
    end
  endfunction

  // ----------------------------------------------------------------
  // register next state
  // ----------------------------------------------------------------
  always @* begin
    primary_enable_reg_nxt        = primary_enable_reg_r;
    primary_priority_select_nxt   = primary_priority_select_r;
    secondary_enable_priority_nxt = secondary_enable_priority_r;
    if (hit_enable) begin
      if (sfr_bit_wr) begin
        primary_enable_reg_nxt = merge_bit(primary_enable_reg_r, sfr_bit_sel,
                                           sfr_wdata[0]);
      end else begin
        primary_enable_reg_nxt = sfr_wdata;
      end
    end
    if (hit_priority) begin
      // unimplemented bit 7 always reads back as zero
      if (sfr_bit_wr) begin
        primary_priority_select_nxt = merge_bit(primary_priority_select_r, sfr_bit_sel,
                                                sfr_wdata[0]) & `MASK_PRIORITY;
      end else begin
        primary_priority_select_nxt = sfr_wdata & `MASK_PRIORITY;
      end
    end
    if (hit_secondary) begin
      // bit 7 and the must-be-zero bit 3 keep their reset values
      secondary_enable_priority_nxt = (sfr_wdata & `MASK_SECONDARY) |
                                      (`RST_SECONDARY & ~`MASK_SECONDARY);
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      primary_enable_reg_r        <= `RST_ENABLE;
      primary_priority_select_r   <= `RST_PRIORITY;
      secondary_enable_priority_r <= `RST_SECONDARY;
    end else begin
      primary_enable_reg_r        <= primary_enable_reg_nxt;
      primary_priority_select_r   <= primary_priority_select_nxt;
      secondary_enable_priority_r <= secondary_enable_priority_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always @* begin
    case (sfr_addr)
      `ADDR_ENABLE:    sfr_rdata = primary_enable_reg_r;
      `ADDR_PRIORITY:  sfr_rdata = primary_priority_select_r;
      `ADDR_SECONDARY: sfr_rdata = secondary_enable_priority_r;
      default:         sfr_rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire [`SEC_FIELD_W-1:0] sec_enable_field;
  wire [`SEC_FIELD_W-1:0] sec_prio_field;
  wire        global_irq_enable;
  wire        ext0_enable;
  wire        timer0_enable;
  wire        ext1_enable;
  wire        timer1_enable;
  wire        uart_enable;
  wire        timer2_enable;
  wire        converter_enable;
  wire        serial_sync_enable;
  wire        supply_monitor_enable;
  wire        interval_counter_enable;
  wire        ext0_prio;
  wire        timer0_prio;
  wire        ext1_prio;
  wire        timer1_prio;
  wire        uart_prio;
  wire        timer2_prio;
  wire        converter_prio;
  wire        serial_sync_prio;
  wire        supply_monitor_prio;
  wire        interval_counter_prio;

  assign sec_enable_field        = secondary_enable_priority_r[`BIT_SEC_ENABLE0 +: `SEC_FIELD_W];
  assign sec_prio_field          = secondary_enable_priority_r[`BIT_SEC_PRIO0 +: `SEC_FIELD_W];
  assign global_irq_enable       = primary_enable_reg_r[`BIT_GLOBAL_EN];
  assign ext0_enable             = primary_enable_reg_r[`POS_EXT0];
  assign timer0_enable           = primary_enable_reg_r[`POS_TIMER0];
  assign ext1_enable             = primary_enable_reg_r[`POS_EXT1];
  assign timer1_enable           = primary_enable_reg_r[`POS_TIMER1];
  assign uart_enable             = primary_enable_reg_r[`POS_UART];
  assign timer2_enable           = primary_enable_reg_r[`POS_TIMER2];
  assign converter_enable        = primary_enable_reg_r[`POS_CONVERTER];
  assign serial_sync_enable      = sec_enable_field[`POS_SEC_SERIAL];
  assign supply_monitor_enable   = sec_enable_field[`POS_SEC_SUPPLY];
  assign interval_counter_enable = sec_enable_field[`POS_SEC_INTERVAL];
  assign ext0_prio               = primary_priority_select_r[`POS_EXT0];
  assign timer0_prio             = primary_priority_select_r[`POS_TIMER0];
  assign ext1_prio               = primary_priority_select_r[`POS_EXT1];
  assign timer1_prio             = primary_priority_select_r[`POS_TIMER1];
  assign uart_prio               = primary_priority_select_r[`POS_UART];
  assign timer2_prio             = primary_priority_select_r[`POS_TIMER2];
  assign converter_prio          = primary_priority_select_r[`POS_CONVERTER];
  assign serial_sync_prio        = sec_prio_field[`POS_SEC_SERIAL];
  assign supply_monitor_prio     = sec_prio_field[`POS_SEC_SUPPLY];
  assign interval_counter_prio   = sec_prio_field[`POS_SEC_INTERVAL];

  // ----------------------------------------------------------------
  // sources in polling order, rank 0 highest
  // ----------------------------------------------------------------
  reg  [`NUM_SRC-1:0] src_req;
  reg  [`NUM_SRC-1:0] src_en;
  reg  [`NUM_SRC-1:0] src_hi;

  always @* begin
    src_req                  = {`NUM_SRC{1'b0}};
    src_req[`RANK_SUPPLY]    = supply_monitor_request;
    src_req[`RANK_WATCHDOG]  = watchdog_request;
    src_req[`RANK_EXT0]      = external_zero_request;
    src_req[`RANK_CONVERTER] = converter_ready_request;
    src_req[`RANK_TIMER0]    = timer_zero_overflow;
    src_req[`RANK_EXT1]      = external_one_request;
    src_req[`RANK_TIMER1]    = timer_one_overflow;
    src_req[`RANK_SERIAL]    = serial_sync_request;
    src_req[`RANK_UART]      = uart_rx_tx_request;
    src_req[`RANK_TIMER2]    = timer_two_request;
    src_req[`RANK_INTERVAL]  = interval_counter_request;
  end

  // watchdog has no enable bit of its own, so only the global enable gates it
  always @* begin
    src_en                   = {`NUM_SRC{1'b0}};
    src_en[`RANK_SUPPLY]     = supply_monitor_enable;
    src_en[`RANK_WATCHDOG]   = 1'b1;
    src_en[`RANK_EXT0]       = ext0_enable;
    src_en[`RANK_CONVERTER]  = converter_enable;
    src_en[`RANK_TIMER0]     = timer0_enable;
    src_en[`RANK_EXT1]       = ext1_enable;
    src_en[`RANK_TIMER1]     = timer1_enable;
    src_en[`RANK_SERIAL]     = serial_sync_enable;
    src_en[`RANK_UART]       = uart_enable;
    src_en[`RANK_TIMER2]     = timer2_enable;
    src_en[`RANK_INTERVAL]   = interval_counter_enable;
  end

  // watchdog shares the external 0 priority bit
  always @* begin
    src_hi                   = {`NUM_SRC{1'b0}};
    src_hi[`RANK_SUPPLY]     = supply_monitor_prio;
    src_hi[`RANK_WATCHDOG]   = ext0_prio;
    src_hi[`RANK_EXT0]       = ext0_prio;
    src_hi[`RANK_CONVERTER]  = converter_prio;
    src_hi[`RANK_TIMER0]     = timer0_prio;
    src_hi[`RANK_EXT1]       = ext1_prio;
    src_hi[`RANK_TIMER1]     = timer1_prio;
    src_hi[`RANK_SERIAL]     = serial_sync_prio;
    src_hi[`RANK_UART]       = uart_prio;
    src_hi[`RANK_TIMER2]     = timer2_prio;
    src_hi[`RANK_INTERVAL]   = interval_counter_prio;
  end

  // ----------------------------------------------------------------
  // rank and vector helpers
  // ----------------------------------------------------------------
  // lowest set index wins, which is the highest polling rank
  function [3:0] first_set;
    input [`NUM_SRC-1:0] v;
    integer i;
    begin
      first_set = `RANK_NONE;
      for (i = `NUM_SRC - 1; i >= 0; i = i - 1) begin
        if (v[i]) begin
          first_set = i[3:0];
        end
      end
    end
  endfunction

  // vector slot per rank; only the external 0 slot is pinned down
  function [3:0] slot_of;
    input [3:0] r;
    begin
      case (r)
        `RANK_SUPPLY:    slot_of = `SLOT_SUPPLY;
        `RANK_WATCHDOG:  slot_of = `SLOT_WATCHDOG;
        `RANK_EXT0:      slot_of = `SLOT_EXT0;
        `RANK_CONVERTER: slot_of = `SLOT_CONVERTER;
        `RANK_TIMER0:    slot_of = `SLOT_TIMER0;
        `RANK_EXT1:      slot_of = `SLOT_EXT1;
        `RANK_TIMER1:    slot_of = `SLOT_TIMER1;
        `RANK_SERIAL:    slot_of = `SLOT_SERIAL;
        `RANK_UART:      slot_of = `SLOT_UART;
        `RANK_TIMER2:    slot_of = `SLOT_TIMER2;
        default:         slot_of = `SLOT_INTERVAL;
      endcase
    end
  endfunction

  function [15:0] vec_of;
    input [3:0] r;
    begin
      vec_of = `VEC_BASE + (`VEC_STEP * {12'h000, slot_of(r)});
    end
  endfunction

  // ----------------------------------------------------------------
  // arbitration and nesting
  // ----------------------------------------------------------------
  wire [`NUM_SRC-1:0] live;
  wire [`NUM_SRC-1:0] live_hi;
  wire [`NUM_SRC-1:0] live_lo;
  wire                take_hi;
  wire                take_lo;
  wire [3:0]          win;
  wire                accept;
  wire                release_level;

  assign live     = src_req & src_en & {`NUM_SRC{global_irq_enable}};
  assign live_hi  = live & src_hi;
  assign live_lo  = live & ~src_hi;
  // high level only waits for a high routine; low waits for any routine
  assign take_hi  = (|live_hi) && !in_service_high;
  assign take_lo  = (|live_lo) && !in_service_high && !in_service_low;
  assign win      = take_hi ? first_set(live_hi) : first_set(live_lo);
  assign irq_req  = take_hi || take_lo;
  assign accept   = irq_req && irq_ack;
  // a return in the accept cycle is dropped so the new level is not lost
  assign release_level = irq_return && !accept;

  // ----------------------------------------------------------------
  // in-service levels
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      in_service_high <= 1'b0;
      in_service_low  <= 1'b0;
    end else if (accept) begin
      if (take_hi) begin
        in_service_high <= 1'b1;
      end else begin
        in_service_low <= 1'b1;
      end
    end else if (release_level) begin
      // the innermost routine is the high one whenever it is active
      if (in_service_high) begin
        in_service_high <= 1'b0;
      end else begin
        in_service_low <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // vectoring to the core
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq_push_pc <= 1'b0;
    end else begin
      irq_push_pc <= accept;
    end
  end

  // vector and rank stand until the next accept
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq_vector <= `RST_VECTOR;
      irq_rank   <= `RST_RANK;
    end else if (accept) begin
      irq_vector <= vec_of(win);
      irq_rank   <= win;
    end
  end

endmodule // irq_prio
`default_nettype wire

/* verification/irq_prio_asserts.sv */
// port checker for irq_prio; bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module irq_prio_asserts (input wire logic sys_clk, nrst, irq_ack, irq_return, irq_req,
  irq_push_pc, in_service_high, in_service_low, input wire logic [7:0] sfr_addr, sfr_rdata,
  input wire logic [15:0] irq_vector, input wire logic [3:0] irq_rank);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_take; irq_req && irq_ack; endsequence
  chk_push_after: assert property (s_take |=> irq_push_pc) else $error("push");
  chk_ext0_vec: assert property (irq_push_pc && irq_rank == 4'h2 |-> irq_vector == 16'h3)
    else $error("vector");
  chk_global_gate: assert property (sfr_addr == 8'ha8 && !sfr_rdata[7] |-> !irq_req)
    else $error("gate");
  chk_same_level: assert property (in_service_high |-> !irq_req) else $error("level");
  chk_nest_high: assert property (s_take ##0 in_service_low |=> in_service_high)
    else $error("nest");
  chk_high_release: assert property (irq_return && in_service_high && !irq_ack |=>
    !in_service_high) else $error("release");
  chk_prio_bit7: assert property (sfr_addr == 8'hb8 |-> !sfr_rdata[7]) else $error("b8");
  chk_sec_fixed: assert property (sfr_addr == 8'ha9 |-> sfr_rdata[7] && !sfr_rdata[3])
    else $error("a9");
endmodule // irq_prio_asserts
`default_nettype wire

/* verification/core_model.sv */
// core side: acks a pending request, returns when asked; one clock
`timescale 1ns/1ps
`default_nettype none
module core_model (input wire logic sys_clk, nrst, irq_req, ret_go,
  output var logic irq_ack, irq_return);
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) {irq_ack, irq_return} <= 2'b00;
    else {irq_ack, irq_return} <= {irq_req && !irq_ack, ret_go};
  end
endmodule // core_model
`default_nettype wire

/* verification/tb.sv */
// bench for irq_prio with the core model; checker bound at the foot
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 0, nrst = 0, sfr_wr = 0, sfr_bit_wr = 0, ret_go = 0, irq_ack, irq_return;
  logic irq_req, irq_push_pc, in_service_high, in_service_low;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata;
  logic [15:0] irq_vector; logic [10:0] q = 0; logic [3:0] irq_rank; logic [2:0] sfr_bit_sel = 0;
  int num_errors = 0, samples_checked = 0, cyc = 0;
  // rows: enable, priority, secondary, requests, expected rank (f = none)
  logic [39:0] rows [6] = '{40'hff00077ff0, 40'hff40077ff3, 40'hff00177ff7,
    40'h8100000042, 40'h800044401a, 40'h7f00077fff};
  irq_prio dut (.sys_clk(sys_clk), .nrst(nrst), .sfr_wr(sfr_wr), .sfr_bit_wr(sfr_bit_wr),
    .sfr_addr(sfr_addr), .sfr_bit_sel(sfr_bit_sel), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .supply_monitor_request(q[0]), .watchdog_request(q[1]),
    .external_zero_request(q[2]), .converter_ready_request(q[3]), .timer_zero_overflow(q[4]),
    .external_one_request(q[5]), .timer_one_overflow(q[6]), .serial_sync_request(q[7]),
    .uart_rx_tx_request(q[8]), .timer_two_request(q[9]), .interval_counter_request(q[10]),
    .irq_ack(irq_ack), .irq_return(irq_return), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_rank(irq_rank), .irq_push_pc(irq_push_pc), .in_service_high(in_service_high),
    .in_service_low(in_service_low));
  core_model core (.sys_clk(sys_clk), .nrst(nrst), .irq_req(irq_req), .ret_go(ret_go),
    .irq_ack(irq_ack), .irq_return(irq_return));
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (++cyc > 3000) begin num_errors++; stop_test(); end
  task automatic chk(input logic [15:0] g, e); samples_checked++;
    if (g !== e) begin num_errors++; $display("Error %0t got %h want %h", $time, g, e); end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge sys_clk) {sfr_addr, sfr_wdata, sfr_wr} <= {a, d, 1'b1};
    @(posedge sys_clk) sfr_wr <= 0; endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge sys_clk) sfr_addr <= a; #1 chk(sfr_rdata, e); endtask
  task automatic take(input logic [3:0] e);
    for (int n = 0; n < 8 && irq_push_pc !== 1'b1; n++) @(posedge sys_clk) #1;
    chk(irq_push_pc ? irq_rank : 4'hf, e); endtask
  task automatic ret(); @(posedge sys_clk) {q, ret_go} <= {11'h0, 1'b1};
    @(posedge sys_clk) ret_go <= 0; repeat (2) @(posedge sys_clk); #1; endtask
  task automatic stop_test(); $display("errors %0d of %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish; endtask
  initial begin
    repeat (8) @(posedge sys_clk); nrst <= 1;
    foreach (rows[i]) begin
      wr(8'hb8, rows[i][31:24]); wr(8'ha9, rows[i][23:16]); wr(8'ha8, rows[i][39:32]);
      q <= rows[i][14:4]; take(rows[i][3:0]);
      if (rows[i][3:0] == 4'h2) chk(irq_vector, 16'h3);
      ret(); end
    // low ext0 in service, then a high timer 0 nests over it
    wr(8'hb8, 8'h02); wr(8'ha8, 8'h83); q <= 11'h004; take(4'h2);
    repeat (3) @(posedge sys_clk); #1 chk(irq_req, 0);
    @(posedge sys_clk) q <= 11'h014;
    take(4'h4); ret(); chk({in_service_high, in_service_low}, 2'b01);
    ret(); chk(in_service_low, 0); @(posedge sys_clk) nrst <= 0;
    @(posedge sys_clk) nrst <= 1; rd(8'ha8, 8'h00); rd(8'hb8, 8'h00);
    rd(8'ha9, 8'ha0); wr(8'ha9, 8'hf7); rd(8'ha9, 8'hf7);
    // bit write of b8h bit 1: address, bit select, data, strobe
    @(posedge sys_clk) {sfr_addr, sfr_bit_sel, sfr_wdata, sfr_bit_wr} <= 20'hb8203;
    @(posedge sys_clk) sfr_bit_wr <= 0; rd(8'hb8, 8'h02);
    stop_test();
  end
endmodule // tb
bind irq_prio irq_prio_asserts asrt (.sys_clk(sys_clk), .nrst(nrst), .irq_ack(irq_ack),
  .irq_return(irq_return), .irq_req(irq_req), .irq_push_pc(irq_push_pc),
  .in_service_high(in_service_high), .in_service_low(in_service_low), .sfr_addr(sfr_addr),
  .sfr_rdata(sfr_rdata), .irq_vector(irq_vector), .irq_rank(irq_rank));
`default_nettype wire
